// *** rtl/cit_pkg.sv ***
package cit_pkg;
    // Oscillator clocks per machine cycle and per legacy timer tick
    localparam int CLK_PER_MC = 4;
    localparam int CLK_PER_TICK_LEGACY = 12;
    localparam int CLK_PER_TICK_FAST = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] PHASE_ALE = 2'h0;
    // Timer prescale: legacy counts 0..2 machine cycles
    localparam logic [1:0] TICK_DIV_LAST = 2'h2;
    // Machine cycle counts per instruction class
    localparam logic [3:0] MC_ONE = 4'h1;
    localparam logic [3:0] MC_TWO = 4'h2;
    localparam logic [3:0] MC_THREE = 4'h3;
    localparam logic [3:0] MC_FOUR = 4'h4;
    localparam logic [3:0] MC_FIVE = 4'h5;
    // External move: 8..36 clocks, i.e. 2..9 machine cycles
    localparam logic [3:0] MC_XMOVE_MIN = 4'h2;
    localparam logic [3:0] MC_XMOVE_MAX = 4'h9;
    localparam logic [2:0] STRETCH_MAX = 3'h7;
    // Sequencer states, Gray along fetch -> execute
    typedef enum logic [1:0] {
        CIT_IDLE = 2'b00,
        CIT_FETCH = 2'b01,
        CIT_EXEC = 2'b11
    } cit_state_t;
endpackage

// *** rtl/cit_mc_count.sv ***
`timescale 1ns/1ps
// Opcode to machine-cycle count lookup, registered output
module cit_mc_count
    import cit_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] opcode,
    input wire logic [2:0] stretch,
    input wire logic xmove_internal,
    output logic [3:0] mc_count
);
    // Class decode of the standard opcode map
    function automatic logic [3:0] opcode_cycles(input logic [7:0] op);
        logic [3:0] lo;
        logic [3:0] hi;
        lo = op[3:0];
        hi = op[7:4];
        opcode_cycles = MC_ONE;
        if (op == 8'ha4 || op == 8'h84) begin
            opcode_cycles = MC_FIVE;
        end else if (op == 8'h12 || op == 8'h02 || op == 8'h22 || op == 8'h32) begin
            opcode_cycles = MC_FOUR;
        end else if (hi >= 4'hb && lo >= 4'h4 && hi == 4'hb) begin
            opcode_cycles = (lo == 4'h4 || lo == 4'h5 || lo >= 4'h6) ? MC_FOUR : MC_ONE;
        end else if (op == 8'h10 || op == 8'h20 || op == 8'h30 || op == 8'hd5) begin
            opcode_cycles = MC_FOUR;
        end else if (lo == 4'h1) begin
            opcode_cycles = MC_THREE;
        end else if (op == 8'h80 || op == 8'h73 || op == 8'h60 || op == 8'h70 ||
                     op == 8'h40 || op == 8'h50 || (hi == 4'hd && lo >= 4'h8)) begin
            opcode_cycles = MC_THREE;
        end else if (op == 8'h90 || op == 8'ha3 || op == 8'h93 || op == 8'h83 ||
                     op == 8'h85 || op == 8'h43 || op == 8'h53 || op == 8'h63 ||
                     op == 8'h75) begin
            opcode_cycles = MC_THREE;
        end else if (op == 8'he0 || op == 8'he2 || op == 8'he3 || op == 8'hf0 ||
                     op == 8'hf2 || op == 8'hf3) begin
            opcode_cycles = MC_TWO;
        end else if (lo == 4'h5 || lo == 4'h2 || (lo == 4'h4 && hi <= 4'h9 && hi != 4'h8 && hi != 4'ha) ||
                     (hi == 4'h7 && lo >= 4'h6) || (hi == 4'h8 && lo >= 4'h6) ||
                     (hi == 4'ha && lo >= 4'h6) || op == 8'hc0 || op == 8'hd0 ||
                     op == 8'hb0 || op == 8'ha0 || op == 8'h82 || op == 8'h92) begin
            opcode_cycles = MC_TWO;
        end
    endfunction

    wire logic [7:0] op_w = opcode;
    wire logic is_xmove = (op_w == 8'he0 || op_w == 8'he2 || op_w == 8'he3 ||
                           op_w == 8'hf0 || op_w == 8'hf2 || op_w == 8'hf3);
    // On-chip moves never stretch; off-chip adds stretch cycles
    wire logic [3:0] xmove_cycles = xmove_internal ? MC_XMOVE_MIN : (MC_XMOVE_MIN + {1'b0, stretch});
    wire logic [3:0] cycles_next = is_xmove ? xmove_cycles : opcode_cycles(op_w);

    // Result registered so the sequencer sees a stable count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mc_count <= MC_ONE;
        end else begin
            mc_count <= cycles_next;
        end
    end
endmodule

// *** rtl/cit_timer_tick.sv ***
`timescale 1ns/1ps
// Timer prescaler: one tick per 12 or per 4 oscillator clocks
module cit_timer_tick
    import cit_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic mc_end,
    input wire logic fast_mode,
    output logic timer_tick
);
    logic [1:0] div_reg; // Machine cycles inside a legacy tick
    wire logic div_wrap = (div_reg == TICK_DIV_LAST);
    wire logic tick_next = mc_end && (fast_mode || div_wrap);

    // Prescale counter runs on machine-cycle boundaries
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div_reg <= 2'h0;
            timer_tick <= 1'b0;
        end else begin
            timer_tick <= tick_next;
            if (mc_end) begin
                div_reg <= (div_wrap || fast_mode) ? 2'h0 : div_reg + 2'h1;
            end
        end
    end
endmodule

// *** rtl/cit_core_timing.sv ***
`timescale 1ns/1ps
module cit_core_timing
    import cit_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] opcode,
    input wire logic opcode_valid,
    input wire logic [2:0] stretch,
    input wire logic xmove_internal,
    input wire logic timer_fast,
    output logic ale,
    output logic fetch_req,
    output logic insn_done,
    output logic [3:0] insn_cycles,
    output logic timer_tick,
    output logic busy
);
    cit_state_t state_reg;
    cit_state_t state_next;
    logic [1:0] phase_reg; // Oscillator clock inside machine cycle
    logic [3:0] mc_left_reg; // Machine cycles still to run
    logic [3:0] mc_left_next;
    logic [3:0] mc_count; // Decoded cycle count, one clock late
    logic fast_reg; // Timer rate selection held by software

    // Static design: state only moves on clock edges, so any slower clock works
    wire logic mc_end = (phase_reg == PHASE_LAST);
    wire logic ale_next = (phase_reg == PHASE_LAST); // One pulse, leads phase zero
    wire logic last_mc = (mc_left_reg == 4'h1);

    cit_mc_count u_count (
        .clock(clock),
        .rst(rst),
        .opcode(opcode),
        .stretch(stretch),
        .xmove_internal(xmove_internal),
        .mc_count(mc_count)
    );

    logic tick_raw;
    cit_timer_tick u_tick (
        .clock(clock),
        .rst(rst),
        .mc_end(mc_end),
        .fast_mode(fast_reg),
        .timer_tick(tick_raw)
    );

    // Sequencer: fetch phase decodes, execute counts machine cycles
    always_comb begin
        state_next = state_reg;
        mc_left_next = mc_left_reg;
        case (state_reg)
            CIT_IDLE: begin
                if (mc_end && opcode_valid) begin
                    state_next = CIT_FETCH;
                end
            end
            CIT_FETCH: begin
                // Count from table; fetch of this opcode was its first cycle
                state_next = CIT_EXEC;
                mc_left_next = mc_count;
            end
            CIT_EXEC: begin
                if (mc_end) begin
                    if (last_mc) begin
                        state_next = CIT_IDLE; // Next fetch released only now
                        mc_left_next = 4'h0;
                    end else begin
                        mc_left_next = mc_left_reg - 4'h1;
                    end
                end
            end
            default: begin
                state_next = CIT_IDLE;
                mc_left_next = 4'h0;
            end
        endcase
    end

    // Fetch is latched at end of a cycle; decode fills in before phase one ends
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= CIT_IDLE;
            mc_left_reg <= 4'h0;
            phase_reg <= PHASE_ALE;
        end else begin
            state_reg <= state_next;
            mc_left_reg <= mc_left_next;
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // Timer rate defaults to legacy twelve clocks
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fast_reg <= 1'b0;
        end else begin
            fast_reg <= timer_fast;
        end
    end

    // Registered outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ale <= 1'b0;
            fetch_req <= 1'b0;
            insn_done <= 1'b0;
            insn_cycles <= 4'h0;
            timer_tick <= 1'b0;
            busy <= 1'b0;
        end else begin
            ale <= ale_next;
            fetch_req <= (state_reg == CIT_IDLE) && mc_end && opcode_valid;
            insn_done <= (state_reg == CIT_EXEC) && mc_end && last_mc;
            if (state_reg == CIT_FETCH) begin
                insn_cycles <= mc_count;
            end
            timer_tick <= tick_raw;
            busy <= (state_next != CIT_IDLE);
        end
    end

    // Only timing is produced here; datapath results are untouched

    // Assertion helpers
    logic [7:0] ale_gap; // Clocks since last address latch pulse
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ale_gap <= 8'h0;
        end else begin
            ale_gap <= ale ? 8'h1 : ale_gap + 8'h1;
        end
    end

    // Clocks spent in execute for the running instruction
    // Cleared while decoding, so each instruction is timed on its own
    logic [7:0] exec_clk;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            exec_clk <= 8'h0;
        end else if (state_reg == CIT_FETCH) begin
            exec_clk <= 8'h0;
        end else if (state_reg == CIT_EXEC) begin
            exec_clk <= exec_clk + 8'h1;
        end
    end

    // Instruction taken from the far side
    sequence s_fetch;
        fetch_req;
    endsequence

    // Decode cycle of a five-cycle instruction: multiply, divide, or an off-chip move with stretch 3
    sequence s_decode_long;
        (state_reg == CIT_FETCH) && (mc_count == MC_FIVE);
    endsequence

    // Any decode cycle
    sequence s_decode;
        state_reg == CIT_FETCH;
    endsequence

    // Last machine cycle has ended
    sequence s_done;
        insn_done;
    endsequence

    // Strobe repeats exactly one machine cycle later
    a_ale_period: assert property (@(posedge clock) disable iff (rst)
        ale |-> ##4 ale) else $error("ale not every four clocks");

    // No second strobe inside one machine cycle
    a_ale_single: assert property (@(posedge clock) disable iff (rst)
        ale |=> !ale [*3]) else $error("extra ale in cycle");

    // Strobe never goes missing, right after reset too
    a_ale_gap: assert property (@(posedge clock) disable iff (rst)
        ale_gap <= 8'h4) else $error("ale gap too long");

    // Strobe marks the first clock of the machine cycle
    a_ale_phase: assert property (@(posedge clock) disable iff (rst)
        ale |-> (phase_reg == PHASE_ALE)) else $error("ale off phase zero");

    // Phase counter steps by one each clock, wrapping at four
    a_phase_step: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) |-> (phase_reg == $past(phase_reg) + 2'h1)) else $error("phase skipped");

    // Legacy rate: nothing for eleven clocks after a tick, checked over eight
    a_tick_legacy: assert property (@(posedge clock) disable iff (rst)
        (timer_tick && !fast_reg && $stable(fast_reg)) |=> !timer_tick [*8]) else $error("legacy tick early");

    // Legacy rate: the next tick is never later than twelve clocks
    a_tick_slow_due: assert property (@(posedge clock) disable iff (rst)
        (timer_tick && !fast_reg) |-> ##[1:12] timer_tick) else $error("legacy tick missing");

    // Fast rate: next tick within twelve clocks
    a_tick_fast: assert property (@(posedge clock) disable iff (rst)
        (timer_tick && fast_reg) |-> ##[1:12] timer_tick) else $error("fast tick missing");

    // Fast rate: no tick sooner than one machine cycle
    a_tick_fast_gap: assert property (@(posedge clock) disable iff (rst)
        (timer_tick && fast_reg && $stable(fast_reg)) |=> !timer_tick [*3]) else $error("fast tick early");

    // Ticks are single-clock pulses
    a_tick_pulse: assert property (@(posedge clock) disable iff (rst)
        timer_tick |=> !timer_tick) else $error("tick too wide");

    // Multiply and divide finish within five machine cycles
    a_mul_five: assert property (@(posedge clock) disable iff (rst)
        (state_reg == CIT_FETCH && mc_count == MC_FIVE) |-> ##[1:21] insn_done) else $error("multiply slow");

    // Multiply and divide take exactly twenty clocks
    a_mul_exact: assert property (@(posedge clock) disable iff (rst)
        s_decode_long |-> ##20 insn_done) else $error("multiply not twenty clocks");

    // No fetch while an instruction runs
    a_no_refetch: assert property (@(posedge clock) disable iff (rst)
        (state_reg == CIT_EXEC) |-> !fetch_req) else $error("fetch during execute");

    // Completion lands on a machine-cycle boundary
    a_done_aligned: assert property (@(posedge clock) disable iff (rst)
        insn_done |-> $past(mc_end)) else $error("done off boundary");

    // Decoded count stays within one to nine machine cycles
    a_xmove_range: assert property (@(posedge clock) disable iff (rst)
        (state_reg == CIT_FETCH) |-> (mc_count >= MC_ONE && mc_count <= MC_XMOVE_MAX)) else $error("bad count");

    // Execute follows every fetch
    a_fetch_exec: assert property (@(posedge clock) disable iff (rst)
        s_fetch |-> ##[1:4] (state_reg == CIT_EXEC)) else $error("no execute after fetch");

    // Fetch pulse comes only with the move out of idle
    a_fetch_state: assert property (@(posedge clock) disable iff (rst)
        fetch_req |-> (state_reg == CIT_FETCH)) else $error("fetch outside decode");

    // Fetch and completion are single-clock pulses
    a_fetch_pulse: assert property (@(posedge clock) disable iff (rst)
        fetch_req |=> !fetch_req) else $error("fetch too wide");
    a_done_pulse: assert property (@(posedge clock) disable iff (rst)
        s_done |=> !insn_done) else $error("done too wide");

    // Completion returns the sequencer to idle
    a_done_idle: assert property (@(posedge clock) disable iff (rst)
        s_done |-> (state_reg == CIT_IDLE)) else $error("done but not idle");

    // Busy covers the whole execute phase
    a_busy_exec: assert property (@(posedge clock) disable iff (rst)
        (state_reg == CIT_EXEC) |-> busy) else $error("busy low in execute");

    // Counter loaded from the decoded count, reported unchanged
    a_count_load: assert property (@(posedge clock) disable iff (rst)
        s_decode |=> (state_reg == CIT_EXEC && mc_left_reg == insn_cycles)) else $error("count not loaded");

    // Reported count holds while the instruction runs
    a_cycles_hold: assert property (@(posedge clock) disable iff (rst)
        (state_reg == CIT_EXEC) |=> $stable(insn_cycles)) else $error("count moved");

    // Remaining count never zero or out of range during execute
    a_left_range: assert property (@(posedge clock) disable iff (rst)
        (state_reg == CIT_EXEC) |-> (mc_left_reg != 4'h0 && mc_left_reg <= MC_XMOVE_MAX)) else $error("bad remaining");

    // Whole instruction, decode clock included, is four clocks per machine cycle
    // The decode clock sits inside the first cycle, so execute is one clock short
    a_exec_span: assert property (@(posedge clock) disable iff (rst)
        s_done |-> ((exec_clk + 8'h1) == {2'b00, insn_cycles, 2'b00})) else $error("wrong instruction length");
endmodule

// *** sim/cit_mem_model.sv ***
`timescale 1ns/1ps
// Program memory stand-in on the far side of the fetch handshake
module cit_mem_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] next_op, // Byte the bench wants fetched
    input wire logic have_op, // A byte is queued
    input wire logic fetch_req,
    input wire logic insn_done,
    output logic [7:0] opcode,
    output logic opcode_valid
);
    logic pending_reg; // Byte taken, instruction still running
    // Hold the byte for the whole access; once released show its inverse, never a stale copy
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pending_reg <= 1'b0;
            opcode <= 8'h00;
            opcode_valid <= 1'b0;
        end else if (fetch_req) begin
            pending_reg <= 1'b1;
            opcode_valid <= 1'b0;
        end else if (pending_reg && insn_done) begin
            pending_reg <= 1'b0;
            opcode <= ~opcode;
        end else if (!pending_reg) begin
            opcode <= next_op;
            opcode_valid <= have_op;
        end
    end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_tests++; if ((exp) !== (got)) begin n_errors++; \
    $display("mismatch %s exp=%0h got=%0h", what, exp, got); end end
module tb;
    import cit_pkg::*;
    typedef struct {logic [7:0] op; logic [2:0] st; logic xi; logic [3:0] n;} cit_row_t;
    logic clock, rst, xmove_internal, timer_fast, have_op;
    logic [2:0] stretch;
    logic [7:0] next_op, opcode;
    logic opcode_valid, ale, fetch_req, insn_done, timer_tick, busy;
    logic [3:0] insn_cycles;
    int n_errors = 0;
    int n_tests = 0;
    int na, nt;
    // Opcode, stretch, on-chip flag, expected machine cycles
    cit_row_t rows [20] = '{
        '{8'h78, 3'h0, 1'b0, 4'h2}, '{8'hd5, 3'h0, 1'b0, 4'h4},
        '{8'h00, 3'h0, 1'b0, 4'h1}, '{8'h24, 3'h0, 1'b0, 4'h2},
        '{8'h85, 3'h0, 1'b0, 4'h3}, '{8'h75, 3'h0, 1'b0, 4'h3},
        '{8'ha4, 3'h0, 1'b0, 4'h5}, '{8'h84, 3'h0, 1'b0, 4'h5},
        '{8'he0, 3'h0, 1'b0, 4'h2}, '{8'he0, 3'h7, 1'b0, 4'h9},
        '{8'hf0, 3'h7, 1'b1, 4'h2}, '{8'h90, 3'h0, 1'b0, 4'h3},
        '{8'h93, 3'h0, 1'b0, 4'h3}, '{8'ha3, 3'h0, 1'b0, 4'h3},
        '{8'h12, 3'h0, 1'b0, 4'h4}, '{8'hb4, 3'h0, 1'b0, 4'h4},
        '{8'h22, 3'h0, 1'b0, 4'h4}, '{8'h80, 3'h0, 1'b0, 4'h3},
        '{8'h60, 3'h0, 1'b0, 4'h3}, '{8'h73, 3'h0, 1'b0, 4'h3}};
    cit_core_timing cit_core_timing_i (.clock(clock), .rst(rst), .opcode(opcode), .opcode_valid(opcode_valid),
        .stretch(stretch), .xmove_internal(xmove_internal), .timer_fast(timer_fast), .ale(ale),
        .fetch_req(fetch_req), .insn_done(insn_done), .insn_cycles(insn_cycles), .timer_tick(timer_tick),
        .busy(busy));
    cit_mem_model cit_mem_model_i (.clock(clock), .rst(rst), .next_op(next_op), .have_op(have_op),
        .fetch_req(fetch_req), .insn_done(insn_done), .opcode(opcode), .opcode_valid(opcode_valid));
    // Free-running 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Print counts and verdict, then stop
    task summarize();
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Queue one byte and wait, bounded, until it is taken
    task start_op(input logic [7:0] op, input logic [2:0] st, input logic xi);
        int w;
        w = 0;
        @(posedge clock) begin
            next_op <= op;
            stretch <= st;
            xmove_internal <= xi;
            have_op <= 1'b1;
        end
        do begin @(posedge clock); #1 w++; end while (fetch_req !== 1'b1 && w < 100);
        @(posedge clock) have_op <= 1'b0;
    endtask
    // Time one instruction from fetch to completion
    task run_row(input cit_row_t r);
        int k;
        k = 1;
        start_op(r.op, r.st, r.xi);
        #1 `CHK("busy", 1'b1, busy)
        do begin @(posedge clock); #1 k++; end while (insn_done !== 1'b1 && k < 100);
        `CHK("insn_cycles", r.n, insn_cycles)
        `CHK("busy at done", 1'b0, busy)
        `CHK("clocks", 1'b1, (k >= 4 * r.n - 1 && k <= 4 * r.n + 2))
    endtask
    // Count address strobes and timer ticks over a span of clocks
    task count_pulses(input int span);
        na = 0;
        nt = 0;
        repeat (span) begin @(posedge clock); #1 na += ale; nt += timer_tick; end
    endtask
    // Main sequence: reset, table rows, timer rates, reset in mid-instruction
    initial begin
        rst = 1'b1;
        next_op = 8'h00;
        have_op = 1'b0;
        stretch = 3'h0;
        xmove_internal = 1'b0;
        timer_fast = 1'b0;
        repeat (2) @(posedge clock);
        #1 `CHK("reset outputs", 5'h00, {ale, busy, fetch_req, insn_done, timer_tick})
        @(posedge clock) rst <= 1'b0;
        foreach (rows[i]) run_row(rows[i]);
        repeat (8) @(posedge clock);
        count_pulses(48);
        `CHK("ale count", 12, na)
        `CHK("slow ticks", 4, nt)
        @(posedge clock) timer_fast <= 1'b1;
        repeat (12) @(posedge clock);
        count_pulses(48);
        `CHK("fast ticks", 12, nt)
        start_op(8'ha4, 3'h0, 1'b0);
        @(posedge clock) rst <= 1'b1;
        #1 `CHK("busy in reset", 1'b0, busy)
        @(posedge clock) rst <= 1'b0;
        run_row(rows[0]);
        summarize();
    end
    // Cut a hang short well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        summarize();
    end
endmodule
